// >>> pkg/alu_ops_defines.svh
// Constants for the accumulator and register-operand datapath
`ifndef ALU_OPS_DEFINES_SVH
`define ALU_OPS_DEFINES_SVH
`define OPC_TOP 2'h0
`define OPC_SUM 4'h7
`define OPC_AND 4'h5
`define OPC_TOP_HI 13
`define OPC_TOP_LO 12
`define OPC_NIB_HI 11
`define OPC_NIB_LO 8
`define SEL_BIT 7
`define IDX_HI 6
`define IDX_LO 0
`define NIB_CARRY 4
`define BYTE_CARRY 8
`define ACC_RESET 8'h00
`define REG_DEPTH 128
`endif

// >>> pkg/alu_ops_pkg.sv
// Types for the accumulator and register-operand datapath
package alu_ops_pkg;
   typedef enum {ph_decode, ph_read, ph_process, ph_write} phase_type;
   typedef enum {op_none, sum_into_target_op, bitwise_conjunction_op} op_type;
   typedef struct packed {
      phase_type phase;
      op_type op;
      logic sel;
      logic [6:0] idx;
      logic [7:0] operand;
      logic [7:0] result;
      logic carry;
      logic nibble;
      logic [7:0] acc;
      logic byte_ovf;
      logic nibble_overflow_flag;
      logic null_flag;
      logic done;
   } state_type;
endpackage

// >>> rtl/reg_file_mem.sv
// Data register memory with registered read port
`timescale 1ns/10ps
`default_nettype none
module reg_file_mem (
   input wire logic clk_sys,
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic wr_en,
   input wire logic [6:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] mem [0:127];
   // No reset on the array; contents are loaded through the write port
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// >>> rtl/sum_and_conjunction_ops.sv
// Four-phase execute unit for the sum and conjunction instructions
`timescale 1ns/10ps
`default_nettype none
`include "alu_ops_defines.svh"
module sum_and_conjunction_ops (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   output logic instr_ready,
   output logic instr_done,
   output logic instr_illegal,
   input wire logic load_en,
   input wire logic [6:0] load_addr,
   input wire logic [7:0] load_data,
   input wire logic [6:0] peek_addr,
   output logic [7:0] peek_data,
   output logic [7:0] acc,
   output logic byte_ovf,
   output logic nibble_overflow_flag,
   output logic null_flag
);
   import alu_ops_pkg::*;

   state_type s_q;
   state_type s_d;
   logic [7:0] mem_rd;
   logic [6:0] rd_addr;
   logic wr_en;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic [1:0] opc_top;
   logic [3:0] opc_nib;
   logic word_sel;
   logic [6:0] word_idx;
   logic is_sum;
   logic is_and;
   logic pick_sum;
   logic [8:0] carry;
   logic [7:0] sum_bits;
   logic [7:0] and_bits;
   logic [7:0] res_now;
   logic [8:0] any_set;
   logic res_zero;
   logic nib_carry;
   logic byte_carry;

   // Instruction word fields
   assign opc_top = instr_word[`OPC_TOP_HI:`OPC_TOP_LO];
   assign opc_nib = instr_word[`OPC_NIB_HI:`OPC_NIB_LO];
   assign word_sel = instr_word[`SEL_BIT];
   assign word_idx = instr_word[`IDX_HI:`IDX_LO];

   // Opcode recognition
   always_comb begin
      is_sum = 1'b0;
      is_and = 1'b0;
      if (opc_top == `OPC_TOP) begin
         is_sum = (opc_nib == `OPC_SUM);
         is_and = (opc_nib == `OPC_AND);
      end
   end

   // Operand read shares the port with peeks outside the read phase
   assign rd_addr = (s_q.phase == ph_read) ? s_q.idx : peek_addr;
   assign peek_data = mem_rd;

   // Per-bit ripple sum, conjunction and result pick
   // A ripple chain is slow, but eight bits fit easily in one 25 ns cycle
   assign pick_sum = (s_q.op == sum_into_target_op);
   assign carry[0] = 1'b0;
   assign any_set[0] = 1'b0;
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign sum_bits[i] = s_q.acc[i] ^ s_q.operand[i] ^ carry[i];
      assign carry[i + 1] = (s_q.acc[i] & s_q.operand[i])
         | (carry[i] & (s_q.acc[i] ^ s_q.operand[i]));
      assign and_bits[i] = s_q.acc[i] & s_q.operand[i];
      assign res_now[i] = pick_sum ? sum_bits[i] : and_bits[i];
      assign any_set[i + 1] = any_set[i] | res_now[i];
   end

   // Carries out of bit 3 and bit 7, null on an all-zero result
   assign nib_carry = carry[`NIB_CARRY];
   assign byte_carry = carry[`BYTE_CARRY];
   assign res_zero = !any_set[8];

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      wr_en = load_en;
      wr_addr = load_addr;
      wr_data = load_data;
      unique case (s_q.phase)
         ph_decode: begin
            // Phase one: decode; illegal words leave the unit idle
            if (instr_valid && (is_sum || is_and)) begin
               if (is_sum) begin
                  s_d.op = sum_into_target_op;
               end else begin
                  s_d.op = bitwise_conjunction_op;
               end
               s_d.sel = word_sel;
               s_d.idx = word_idx;
               s_d.phase = ph_read;
            end
         end
         ph_read: begin
            // Phase two: address the operand; memory output is registered
            s_d.phase = ph_process;
         end
         ph_process: begin
            // Phase three: latch the operand for the adder
            s_d.operand = mem_rd;
            s_d.phase = ph_write;
         end
         ph_write: begin
            // Phase four: commit result and flags
            s_d.result = res_now;
            s_d.null_flag = res_zero;
            if (pick_sum) begin
               s_d.byte_ovf = byte_carry;
               s_d.nibble_overflow_flag = nib_carry;
            end
            if (s_q.sel) begin
               // Overrides the load port for this one cycle
               wr_en = 1'b1;
               wr_addr = s_q.idx;
               wr_data = res_now;
            end else begin
               s_d.acc = res_now;
            end
            s_d.done = 1'b1;
            s_d.phase = ph_decode;
         end
      endcase
   end

   reg_file_mem u_mem (
      .clk_sys(clk_sys),
      .rd_addr(rd_addr),
      .rd_data(mem_rd),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data)
   );

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign instr_ready = (s_q.phase == ph_decode);
   assign instr_illegal = instr_valid && instr_ready && !(is_sum || is_and);
   assign instr_done = s_q.done;
   assign acc = s_q.acc;
   assign byte_ovf = s_q.byte_ovf;
   assign nibble_overflow_flag = s_q.nibble_overflow_flag;
   assign null_flag = s_q.null_flag;
endmodule
`default_nettype wire

// >>> verification/ops_chk_sva.sv
// Checker for the execute unit
`timescale 1ns/10ps
`default_nettype none
module ops_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic instr_done,
   input wire logic instr_illegal,
   input wire logic byte_ovf,
   input wire logic null_flag,
   input wire logic [13:0] instr_word,
   input wire logic [7:0] acc
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Sampled only on the taking edge, since the word may change afterwards
   wire tk = instr_valid && instr_ready && !instr_illegal;
   wire sm = tk && instr_word[9];
   wire d = instr_word[7];
   property p_done; tk |-> ##4 instr_done; endproperty
   a_done: assert property (p_done) else $error("done");
   property p_busy; tk |=> !instr_ready [*3] ##1 instr_ready; endproperty
   a_busy: assert property (p_busy) else $error("busy");
   property p_dec; instr_valid && instr_ready |->
      !instr_illegal == (instr_word[13:8] inside {6'h07, 6'h05}); endproperty
   a_dec: assert property (p_dec) else $error("decode");
   property p_reg; tk && d |-> ##4 acc == $past(acc, 4); endproperty
   a_reg: assert property (p_reg) else $error("acc");
   property p_and; tk && !sm && !d |-> ##4 (acc & ~$past(acc, 4)) == 8'h00; endproperty
   a_and: assert property (p_and) else $error("and");
   property p_flg; tk && !sm |-> ##4 $stable(byte_ovf); endproperty
   a_flg: assert property (p_flg) else $error("flag");
   property p_cy; sm && !d |-> ##4 byte_ovf == (acc < $past(acc, 4)); endproperty
   a_cy: assert property (p_cy) else $error("carry");
   property p_nul; tk && !d |-> ##4 null_flag == (acc == 8'h00); endproperty
   a_nul: assert property (p_nul) else $error("null");
   c_sum: cover property (sm);
   c_and: cover property (tk && !sm);
   c_bad: cover property (instr_illegal);
endmodule
bind sum_and_conjunction_ops ops_chk chk (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .instr_valid(instr_valid),
   .instr_ready(instr_ready),
   .instr_done(instr_done),
   .instr_illegal(instr_illegal),
   .byte_ovf(byte_ovf),
   .null_flag(null_flag),
   .instr_word(instr_word),
   .acc(acc)
);
`default_nettype wire

// >>> verification/sum_and_conjunction_ops_bench.sv
// Bench for the execute unit
`timescale 1ns/10ps
`default_nettype none
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
$display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module sum_and_conjunction_ops_bench;
   logic clk_sys = 1'h0, nrst = 1'h0, instr_valid = 1'h0, load_en = 1'h0;
   logic [13:0] instr_word = 14'h0;
   logic [6:0] load_addr = 7'h0, peek_addr = 7'h0;
   logic [7:0] load_data = 8'h0, peek_data, acc;
   logic instr_ready, instr_done, instr_illegal, byte_ovf, nibble_overflow_flag, null_flag;
   logic [10:0] outs;
   int mismatches = 0, num_checks = 0, cycles = 0;
   assign outs = {acc, byte_ovf, nibble_overflow_flag, null_flag};
   sum_and_conjunction_ops uut (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .instr_ready(instr_ready),
      .instr_done(instr_done),
      .instr_illegal(instr_illegal),
      .load_en(load_en),
      .load_addr(load_addr),
      .load_data(load_data),
      .peek_addr(peek_addr),
      .peek_data(peek_data),
      .acc(acc),
      .byte_ovf(byte_ovf),
      .nibble_overflow_flag(nibble_overflow_flag),
      .null_flag(null_flag)
   );
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic close_out();
      if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys) if (++cycles == 500) begin mismatches++; close_out(); end
   // Peek follows the operand address, so the write shows one edge after done
   task automatic run(input logic [13:0] w, input logic [7:0] v, r, input logic [10:0] e);
      @(posedge clk_sys);
      {load_en, load_addr, load_data, peek_addr} <= {1'h1, w[6:0], v, w[6:0]};
      @(posedge clk_sys);
      {load_en, instr_valid, instr_word} <= {1'h0, 1'h1, w};
      @(posedge clk_sys);
      instr_valid <= 1'h0;
      repeat (3) @(posedge clk_sys);
      #1 `CK({instr_done, outs}, {1'h1, e})
      @(posedge clk_sys);
      #1 `CK(peek_data, r)
   endtask
   task automatic t_ops();
      run(14'h0705, 8'h17, 8'h17, 11'h0b8);
      run(14'h0586, 8'h3e, 8'h16, 11'h0b8);
      run(14'h0787, 8'hf9, 8'h10, 11'h0be);
      run(14'h0508, 8'he8, 8'he8, 11'h007);
   endtask
   task automatic t_bad();
      @(posedge clk_sys);
      {instr_valid, instr_word} <= {1'h1, 14'h0e05};
      #1 `CK(instr_illegal, 1'h1)
      @(posedge clk_sys);
      instr_valid <= 1'h0;
      repeat (3) @(posedge clk_sys);
      #1 `CK({instr_done, outs}, 12'h007)
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      nrst <= 1'h1;
      #1 `CK({instr_ready, instr_done, outs}, 13'h1000)
      t_ops();
      t_bad();
      close_out();
   end
endmodule
`default_nettype wire
